// ===== rtl/swd_supervisor.sv
// module: supply supervisor with watchdog and override reset on one open-drain pin
//
// Notes on behaviour
// - the pin is pulled low at once while the supply is not good, including power-up and power-down.
// - after the supply returns the pin stays low at least 500 ms before release.
// - the pin is open drain: only pulled low or released, never driven high.
// - each strobe-low level seen on the pin restarts the watchdog time-out.
// - with no strobe inside the 700 ms time-out a reset pulse of at least 500 ms is issued.
// - while strobes stay absent a new reset pulse follows every time-out period.
// - a full low on the pin from outside is a reset request passed through a debounce filter.
// - an accepted override request gives a reset of at least 500 ms on the pin.
module swd_supervisor
   import swd_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = RESET_HOLD_CYCLES,
   parameter int unsigned TIMEOUT_CYCLES = WDOG_TIMEOUT_CYCLES,
   parameter int unsigned FILTER_CYCLES = DEBOUNCE_CYCLES
)
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // supply comparator, high while supply is within tolerance
   input wire logic i_power_good,
   // reset_strobe_pin level detectors
   input wire logic i_pin_full_low,
   input wire logic i_strobe_low_level,
   // reset_strobe_pin open-drain driver
   output logic o_reset_strobe_pin_out,
   output logic o_reset_strobe_pin_oe,
   // status
   output logic o_reset_active
);

   // ------------------------------------------------------------
   // counter helpers
   // ------------------------------------------------------------
   // one increment shared by the hold and watchdog counters
   function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] value);
      return value + 28'h000_0001;
   endfunction

   // true on the last cycle of a span of the given length
   function automatic logic cnt_last(input logic [CNT_W-1:0] value, input int unsigned span);
      return value >= CNT_W'(span - 1);
   endfunction

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic pg_s1_reg;
   logic pg_s2_reg;
   logic low_s1_reg;
   logic low_s2_reg;
   logic stb_s1_reg;
   logic stb_s2_reg;

   always_ff @(posedge i_clock)
   begin
      if (!i_nrst)
      begin
         pg_s1_reg <= 1'b0;
         pg_s2_reg <= 1'b0;
         low_s1_reg <= 1'b0;
         low_s2_reg <= 1'b0;
         stb_s1_reg <= 1'b0;
         stb_s2_reg <= 1'b0;
      end
      else
      begin
         pg_s1_reg <= i_power_good;
         pg_s2_reg <= pg_s1_reg;
         low_s1_reg <= i_pin_full_low;
         low_s2_reg <= low_s1_reg;
         stb_s1_reg <= i_strobe_low_level;
         stb_s2_reg <= stb_s1_reg;
      end
   end

   // ------------------------------------------------------------
   // own drive tracking
   // ------------------------------------------------------------
   // the level detector sees our own pull two flops late; the drive is delayed
   // alike, plus one flop for pin rise time, so our pulse never re-arms itself
   logic drive_d1_reg;
   logic drive_d2_reg;
   logic drive_d3_reg;
   logic own_pull;
   logic ext_low;

   always_ff @(posedge i_clock)
   begin
      if (!i_nrst)
      begin
         drive_d1_reg <= 1'b1;
         drive_d2_reg <= 1'b1;
         drive_d3_reg <= 1'b1;
      end
      else
      begin
         drive_d1_reg <= o_reset_active;
         drive_d2_reg <= drive_d1_reg;
         drive_d3_reg <= drive_d2_reg;
      end
   end

   assign own_pull = drive_d2_reg || drive_d3_reg;
   // a full low that we did not cause is an outside reset request
   assign ext_low = low_s2_reg && !own_pull;

   // ------------------------------------------------------------
   // override request filter
   // ------------------------------------------------------------
   logic override_low;
   logic pushbutton_override;

   swd_debounce #(
      .COUNT(FILTER_CYCLES)
   ) u_debounce (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_level(ext_low),
      .o_level(override_low)
   );

   // our own drive also pulls the pin fully low, so only count it while released
   assign pushbutton_override = override_low && !o_reset_active;

   // ------------------------------------------------------------
   // reset hold and watchdog
   // ------------------------------------------------------------
   swd_state_t state_reg;
   swd_state_t state_next;
   logic [CNT_W-1:0] hold_reg;
   logic [CNT_W-1:0] hold_next;
   logic [CNT_W-1:0] wdog_reg;
   logic [CNT_W-1:0] wdog_next;
   logic stb_seen_reg;
   logic strobe_edge;
   logic supply_bad;
   logic hold_done;
   logic wdog_expired;
   logic leave_run;

   assign supply_bad = !pg_s2_reg;
   // a strobe counts once on its falling edge; a level held low still ends in one restart
   assign strobe_edge = stb_s2_reg && !stb_seen_reg;
   // a hold ends only after a full span of good supply
   assign hold_done = cnt_last(hold_reg, HOLD_CYCLES);
   assign wdog_expired = cnt_last(wdog_reg, TIMEOUT_CYCLES);
   // any of the three causes ends the run at once
   assign leave_run = supply_bad || pushbutton_override || wdog_expired;

   always_comb
   begin
      state_next = state_reg;
      hold_next = hold_reg;
      wdog_next = wdog_reg;
      unique case (state_reg)
         SWD_ST_HOLD:
         begin
            wdog_next = CNT_ZERO;
            if (supply_bad)
               hold_next = CNT_ZERO;
            else if (hold_done)
               state_next = SWD_ST_RUN;
            else
               hold_next = cnt_step(hold_reg);
         end
         SWD_ST_RUN:
         begin
            hold_next = CNT_ZERO;
            if (leave_run)
            begin
               state_next = SWD_ST_HOLD;
               wdog_next = CNT_ZERO;
            end
            else if (strobe_edge)
               wdog_next = CNT_ZERO;
            else
               wdog_next = cnt_step(wdog_reg);
         end
         default:
         begin
            // an unused code falls back to holding reset
            state_next = SWD_ST_HOLD;
            hold_next = CNT_ZERO;
            wdog_next = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_nrst)
      begin
         state_reg <= SWD_ST_HOLD;
         hold_reg <= CNT_ZERO;
         wdog_reg <= CNT_ZERO;
         stb_seen_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         hold_reg <= hold_next;
         wdog_reg <= wdog_next;
         stb_seen_reg <= stb_s2_reg;
      end
   end

   // ------------------------------------------------------------
   // pin drive
   // ------------------------------------------------------------
   // the raw supply input bypasses the synchroniser so the pull-down is immediate
   assign o_reset_active = (state_reg == SWD_ST_HOLD) || !i_power_good;
   assign o_reset_strobe_pin_oe = o_reset_active;
   assign o_reset_strobe_pin_out = 1'b0;

endmodule

// ===== rtl/swd_pkg.sv
// package: timing constants and state codes for the supply supervisor watchdog
package swd_pkg;

   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLOCK_PERIOD_NS = 4;
   localparam int unsigned RESET_HOLD_MS = 500;
   localparam int unsigned WDOG_TIMEOUT_MS = 700;
   localparam int unsigned STROBE_MIN_NS = 500;
   localparam int unsigned DEBOUNCE_US = 10;
   localparam int unsigned NS_PER_MS = 1000000;
   localparam int unsigned NS_PER_US = 1000;

   // hold and debounce times round up, the strobe width and the time-out are not rounded
   localparam int unsigned RESET_HOLD_CYCLES = (RESET_HOLD_MS * NS_PER_MS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int unsigned WDOG_TIMEOUT_CYCLES = (WDOG_TIMEOUT_MS * NS_PER_MS) / CLOCK_PERIOD_NS;
   localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_US * NS_PER_US + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int unsigned STROBE_MIN_CYCLES = STROBE_MIN_NS / CLOCK_PERIOD_NS;

   localparam int CNT_W = 28;
   localparam logic [CNT_W-1:0] CNT_ZERO = 28'h000_0000;

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      SWD_ST_HOLD = 2'b00,
      SWD_ST_RUN = 2'b01
   } swd_state_t;

endpackage

// ===== rtl/swd_debounce.sv
// module: stable-level debounce filter for the override request
module swd_debounce
   import swd_pkg::*;
#(
   parameter int unsigned COUNT = DEBOUNCE_CYCLES
)
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // raw synchronised level and filtered result
   input wire logic i_level,
   output logic o_level
);

   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic level_reg;
   logic differs;
   logic settled;

   assign differs = i_level != level_reg;
   assign settled = cnt_reg >= CNT_W'(COUNT - 1);
   assign cnt_next = differs ? cnt_reg + 28'h000_0001 : CNT_ZERO;
   assign o_level = level_reg;

   always_ff @(posedge i_clock)
   begin
      if (!i_nrst)
      begin
         cnt_reg <= CNT_ZERO;
         level_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= (differs && !settled) ? cnt_next : CNT_ZERO;
         if (differs && settled)
            level_reg <= i_level;
      end
   end

endmodule

// ===== tb/swd_chk.sv
// checker: pin timing relations of the supervisor
module swd_chk #(
   parameter int unsigned HOLD_CYCLES = 50,
   parameter int unsigned TIMEOUT_CYCLES = 100,
   parameter int unsigned FILTER_CYCLES = 4
)
(
   // watched ports
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_power_good,
   input wire logic i_pin_full_low,
   input wire logic i_strobe_low_level,
   input wire logic o_reset_strobe_pin_out,
   input wire logic o_reset_strobe_pin_oe,
   input wire logic o_reset_active
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] hi_reg, idle_reg, fl_reg;
   logic ovr_reg;
   wire ext_low = i_pin_full_low && !o_reset_strobe_pin_oe;
   always_ff @(posedge i_clock)
   begin
      if (!i_nrst)
      begin
         hi_reg <= '0;
         idle_reg <= '0;
         fl_reg <= '0;
         ovr_reg <= 1'b0;
      end
      else
      begin
         hi_reg <= o_reset_strobe_pin_oe ? hi_reg + 1'b1 : '0;
         idle_reg <= (o_reset_strobe_pin_oe || $rose(i_strobe_low_level)) ? '0 : idle_reg + 1'b1;
         fl_reg <= ext_low ? fl_reg + 1'b1 : '0;
         // override makes an early pulse legal until the pin is released
         ovr_reg <= ext_low || (ovr_reg && !$fell(o_reset_strobe_pin_oe));
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   supply_low_a: assert property (!i_power_good |-> o_reset_strobe_pin_oe) else $error("supply low, pin free");
   drain_only_a: assert property (o_reset_strobe_pin_out == 1'b0) else $error("pin driven high");
   status_same_a: assert property (o_reset_active == o_reset_strobe_pin_oe) else $error("status differs");
   hold_min_a: assert property ($fell(o_reset_strobe_pin_oe) |-> hi_reg >= HOLD_CYCLES)
      else $error("reset pulse short");
   good_release_a: assert property ($fell(o_reset_strobe_pin_oe) |-> i_power_good && $past(i_power_good, 3))
      else $error("release with bad supply");
   wd_late_a: assert property (idle_reg <= TIMEOUT_CYCLES + 4) else $error("time-out missed");
   wd_early_a: assert property ($rose(o_reset_strobe_pin_oe) && i_power_good && !ovr_reg
      |-> idle_reg >= TIMEOUT_CYCLES - 1) else $error("early time-out");
   ovr_take_a: assert property (fl_reg <= FILTER_CYCLES + 4) else $error("override not taken");
endmodule

// ===== tb/swd_host.sv
// model: host strobing through the divider, and the override switch
module swd_host #(
   parameter int unsigned PERIOD = 300,
   parameter int unsigned WIDTH = 125
)
(
   input wire logic i_clock,
   input wire logic i_pin_oe,
   input wire logic i_strobe_en,
   input wire logic i_override,
   output logic o_full_low,
   output logic o_strobe_low
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] tick_reg;
   logic strobe_reg;
   always_ff @(posedge i_clock)
   begin
      tick_reg <= (!i_strobe_en || tick_reg == 16'(PERIOD - 1)) ? '0 : tick_reg + 1'b1;
      strobe_reg <= i_strobe_en && tick_reg < 16'(WIDTH);
   end
   // everyone only pulls down, so a full low hides the strobe level
   assign o_full_low = i_pin_oe || i_override;
   assign o_strobe_low = strobe_reg && !o_full_low;
endmodule

// ===== tb/swd_supervisor_tb_top.sv
// bench: supply, override and host strobes against pin timing
module swd_supervisor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HOLD = 50;
   localparam int TOUT = 400;
   localparam int FILT = 4;
   logic i_clock, i_nrst, i_power_good, strobe_en, override;
   logic full_low, strobe_low, pin_out, pin_oe, rst_act;
   int n_errors = 0;
   int comparisons = 0;
   int n;
   swd_supervisor #(.HOLD_CYCLES(HOLD), .TIMEOUT_CYCLES(TOUT), .FILTER_CYCLES(FILT)) swd_supervisor_i (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_power_good(i_power_good), .i_pin_full_low(full_low),
      .i_strobe_low_level(strobe_low), .o_reset_strobe_pin_out(pin_out), .o_reset_strobe_pin_oe(pin_oe),
      .o_reset_active(rst_act));
   // strobes spaced under one time-out and held the minimum strobe width
   swd_host #(.PERIOD(TOUT * 3 / 4), .WIDTH(swd_pkg::STROBE_MIN_CYCLES)) swd_host_i (.i_clock(i_clock),
      .i_pin_oe(pin_oe), .i_strobe_en(strobe_en), .i_override(override), .o_full_low(full_low),
      .o_strobe_low(strobe_low));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic wait_oe(input logic v, input int lim, output int cyc);
      cyc = 0;
      while (pin_oe !== v && cyc < lim)
      begin
         @(negedge i_clock);
         cyc++;
      end
   endtask
   task automatic results();
      if (n_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic t_timeout();
      repeat (2)
      begin
         wait_oe(1, TOUT + 20, n);
         check("time-out", n >= TOUT - 1 && n <= TOUT + 1, 1);
         wait_oe(0, HOLD + 20, n);
         check("pulse", n >= HOLD && n <= HOLD + 4, 1);
      end
   endtask
   task automatic t_strobe();
      strobe_en = 1;
      n = 0;
      repeat (4 * TOUT)
      begin
         @(negedge i_clock);
         n += pin_oe;
      end
      check("strobed", n, 0);
      strobe_en = 0;
      wait_oe(1, 2 * TOUT, n);
      check("after strobes", pin_oe, 1);
      wait_oe(0, HOLD + 20, n);
      check("strobe pulse", n >= HOLD && n <= HOLD + 4, 1);
   endtask
   task automatic t_override();
      override = 1;
      repeat (FILT - 2) @(negedge i_clock);
      override = 0;
      repeat (20) @(negedge i_clock);
      check("glitch", pin_oe, 0);
      override = 1;
      wait_oe(1, FILT + 10, n);
      check("override", n >= FILT + 2 && n <= FILT + 4, 1);
      override = 0;
      wait_oe(0, HOLD + 20, n);
      check("override pulse", n >= HOLD - 1, 1);
   endtask
   task automatic t_brownout();
      i_power_good = 0;
      #1;
      check("brownout", pin_oe, 1);
      check("status", rst_act, 1);
      check("drain data", pin_out, 0);
      repeat (5) @(negedge i_clock);
      i_power_good = 1;
      wait_oe(0, HOLD + 20, n);
      check("recovery", n >= HOLD && n <= HOLD + 4, 1);
   endtask
   initial
   begin
      i_clock = 0;
      forever #2 i_clock = ~i_clock;
   end
   initial
   begin
      i_nrst = 0;
      i_power_good = 1;
      strobe_en = 0;
      override = 0;
      repeat (10) @(negedge i_clock);
      check("in reset", pin_oe, 1);
      i_nrst = 1;
      wait_oe(0, HOLD + 20, n);
      check("power-up", n >= HOLD && n <= HOLD + 4, 1);
      t_timeout();
      t_strobe();
      t_override();
      t_brownout();
      results();
   end
   // run needs about 3100 cycles
   initial
   begin
      #40000;
      n_errors++;
      results();
   end
endmodule
bind swd_supervisor swd_chk #(.HOLD_CYCLES(HOLD_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
   .FILTER_CYCLES(FILTER_CYCLES)) swd_chk_i (.i_clock(i_clock), .i_nrst(i_nrst), .i_power_good(i_power_good),
   .i_pin_full_low(i_pin_full_low), .i_strobe_low_level(i_strobe_low_level),
   .o_reset_strobe_pin_out(o_reset_strobe_pin_out), .o_reset_strobe_pin_oe(o_reset_strobe_pin_oe),
   .o_reset_active(o_reset_active));
